//--- cru_consts.svh
// Constants of the cache and relocation unit: geometry, codes, masks, reset values.
`ifndef CRU_CONSTS_SVH
`define CRU_CONSTS_SVH
// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define CRU_LINES 1024
`define CRU_IDX_W 10
`define CRU_TAG_W 7
`define CRU_PA_W 18
`define CRU_HIST_W 6
`define CRU_IO_PAGE 5'h1F
// ----------------------------------------------------------------------------
// Microcontrol decode: code[15:10] groups, code[15:9] groups, code[3:0] selects
// ----------------------------------------------------------------------------
`define CRU_UC_RD_GRP 6'h21
`define CRU_UC_WR_GRP 6'h20
`define CRU_UC_RD_MM2 7'h44
`define CRU_UC_RD_STAT 7'h45
`define CRU_SEL_CCR_SLR 4'h0
`define CRU_SEL_MM0 4'h1
`define CRU_SEL_PDR 4'h2
`define CRU_SEL_PAR 4'h3
`define CRU_WR_CCR_BITS 4'h4
`define CRU_WR_SLR 4'h8
`define CRU_WR_CCR_SLR 4'hC
`define CRU_WR_MM0 4'hD
`define CRU_WR_PDR 4'hE
`define CRU_WR_PAR 4'hF
// ----------------------------------------------------------------------------
// Field positions, writable masks and reset values
// ----------------------------------------------------------------------------
`define CRU_CCR_FMISS_LO 2
`define CRU_CCR_FMISS_HI 3
`define CRU_CCR_WRONG_PAR 6
`define CRU_CCR_PAR_ABORT 7
`define CRU_CCR_MASK 16'h00CC
`define CRU_MM0_MASK 16'hE101
`define CRU_PDR_MASK 16'h7F0E
`define CRU_MM0_RELOC 0
`define CRU_RST_CCR 16'h0000
`define CRU_RST_SLR 8'h00
`endif

//--- cru_pkg.sv
// Types shared by the cache and relocation unit.
package cru_pkg;
    // Bus cycle codes issued by the datapath
    typedef enum logic [2:0] {
        BC_READ_IR = 3'h0, BC_READ_NOINT = 3'h1, BC_WRITE = 3'h2, BC_READ_BYTE = 3'h3,
        BC_READ_LOCK = 3'h4, BC_WRITE_BYTE = 3'h5, BC_READ = 3'h6, BC_INVAL = 3'h7
    } cru_bus_e;
    // Miss handling state
    typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_FILL = 2'h2} cru_fsm_e;
    // One cache entry: tag half and data half, each with parity
    typedef struct packed {
        logic valid;
        logic [6:0] tag;
        logic tpar;
        logic [15:0] data;
        logic [1:0] dpar;
    } cru_line_s;
    // Processor reference request
    typedef struct packed {
        logic valid;
        cru_bus_e kind;
        logic user;
        logic stack;
        logic [15:0] va;
        logic [15:0] wdata;
    } cru_ref_s;
    // Microcontrol transfer
    typedef struct packed {
        logic xfer;
        logic [15:0] code;
        logic [15:0] dout;
    } cru_microcontrol_interface_s;
    // Bus write seen from another master
    typedef struct packed {
        logic valid;
        logic write;
        logic [17:0] addr;
    } cru_dma_s;
endpackage

//--- cru_top.sv
// Cache, relocation, stack limit and hit history unit with its microcontrol port.
`timescale 1ns/10ps
`include "cru_consts.svh"
// Contract
// R1 - Relocate virtual address to physical, send both ways
// R2 - Hit selects cache port; miss fills from bus
// R3 - Other-master writes invalidate matching cache lines
// R4 - Stack below loaded limit raises error
// R5 - 1024-word direct-mapped store, 128 aliases each
// R6 - Tag: seven address bits, valid, parity
// R7 - Data: two bytes, each with parity
// R8 - Control bit 6 writes wrong parity, blocks hit
// R9 - Control bit 7 aborts on parity error
// R10 - Control bit 2 forces misses, lower half
// R11 - Control bit 3 forces misses, upper half
// R12 - History keeps six outcomes, newest in bit 0
// R13 - History cannot be written
// R14 - Registers reachable over microcontrol; read-only stays so
// R15 - Controller enables one input-bus driver per cycle
// R16 - Page register read uses mode and address 15:13
// R17 - Status read puts history on bits 5:0
// R18 - Status two read drives all 16 bits
// R19 - Invalidate code clears line, no bus cycle
// R20 - Word and byte writes go to bus, update cache
// R21 - I/O page never cached
// R22 - Hit needs valid, tag match, good parity, no force
module cru_top import cru_pkg::*; #(
    parameter int HIST_W = `CRU_HIST_W
) (
    input wire logic mclk, // 50 MHz microcycle clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire cru_ref_s ref_i, // Processor reference
    input wire cru_microcontrol_interface_s microcontrol_interface_i, // Microcontrol transfer
    input wire cru_dma_s dma_i, // Bus traffic of other masters
    input wire logic fill_valid, // Bus side has read data on bus_din_i
    input wire logic [15:0] bus_din_i, // Read data returned by the bus side
    output logic [17:0] physical_bus_address, // Relocated address to bus and cache
    output logic sbus_req, // Start a system bus cycle
    output logic sbus_write, // That cycle writes
    output logic hit, // Last read outcome
    output logic data_select_mux, // 1 selects the cache port
    output logic [15:0] mux_data, // Data select mux output
    output logic data_ready, // mux_data valid this cycle
    output logic parity_err, // Cache parity error seen
    output logic access_abort, // Access aborted on parity error
    output logic stack_err, // Stack below limit
    output logic [15:0] bus_din_o, // Register read data
    output logic bus_din_oe // Drives the input bus
);
    localparam int LINES = `CRU_LINES;
    localparam int IW = `CRU_IDX_W;
    localparam int TW = `CRU_TAG_W;

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    cru_line_s cache [LINES];
    logic [15:0] cache_control_reg;
    logic [7:0] stack_limit_reg;
    logic [15:0] mm_status_zero;
    logic [15:0] mm_status_two;
    logic [11:0] page_base_reg [16];
    logic [15:0] page_descriptor_reg [16];
    logic [HIST_W-1:0] hit_miss_history;
    logic [TW-1:0] last_tag;
    logic last_valid;
    cru_fsm_e state;
    logic [IW-1:0] fill_idx;
    logic [TW-1:0] fill_tag;
    logic fill_alloc;
    logic s1_v;
    cru_bus_e s1_kind;
    logic [15:0] s1_wdata;

    // Builds a line; wrong parity flips both tag and data parity
    function automatic cru_line_s mk_line(input logic [TW-1:0] tag, input logic [15:0] data, input logic wrong);
        cru_line_s l;
        l.valid = 1'b1;
        l.tag = tag;
        l.tpar = ^{1'b1, tag} ^ wrong;
        l.data = data;
        l.dpar = {^data[15:8], ^data[7:0]} ^ {2{wrong}};
        return l;
    endfunction

    // ------------------------------------------------------------------------
    // Relocation
    // ------------------------------------------------------------------------
    logic [3:0] page_sel;
    logic [17:0] next_physical_bus_address;
    // Register set follows the processor mode, slot follows address 15:13
    assign page_sel = {ref_i.user, ref_i.va[15:13]}; // see R16
    always_comb begin
        if (mm_status_zero[`CRU_MM0_RELOC]) begin
            next_physical_bus_address = {page_base_reg[page_sel], 6'h00} + {5'h00, ref_i.va[12:0]}; // see R1
        end else if (ref_i.va[15:13] == 3'h7) begin
            next_physical_bus_address = {2'h3, ref_i.va};
        end else begin
            next_physical_bus_address = {2'h0, ref_i.va};
        end
    end

    // Stage one: the relocated address goes out to the bus and into the lookup
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s1_v <= 1'b0;
            s1_kind <= BC_READ;
            s1_wdata <= 16'h0000;
            physical_bus_address <= 18'h0_0000;
        end else begin
            s1_v <= ref_i.valid;
            if (ref_i.valid) begin
                s1_kind <= ref_i.kind;
                s1_wdata <= ref_i.wdata;
                physical_bus_address <= next_physical_bus_address; // see R1
            end
        end
    end

    // Stack check compares against the limit page, one cycle after the request
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stack_err <= 1'b0;
        end else begin
            stack_err <= ref_i.valid && ref_i.stack && (ref_i.va < {stack_limit_reg, 8'h00}); // see R4
        end
    end

    // ------------------------------------------------------------------------
    // Lookup
    // ------------------------------------------------------------------------
    logic [IW-1:0] idx;
    logic [TW-1:0] tag;
    cru_line_s ln;
    logic is_rd, is_wr, io_page, tmatch, pe, forced, lk_hit;
    // Index is the word address below bit 11, so 128 locations share a slot
    assign idx = physical_bus_address[IW:1]; // see R5
    assign tag = physical_bus_address[17:IW+1]; // see R6
    assign ln = cache[idx];
    assign is_rd = !(s1_kind inside {BC_WRITE, BC_WRITE_BYTE, BC_INVAL});
    assign is_wr = s1_kind inside {BC_WRITE, BC_WRITE_BYTE};
    assign io_page = physical_bus_address[17:13] == `CRU_IO_PAGE;
    assign tmatch = ln.valid && (ln.tag == tag);
    // Parity is only judged on a line that claims this address
    assign pe = tmatch && ((ln.tpar != ^{ln.valid, ln.tag})
                || (ln.dpar != {^ln.data[15:8], ^ln.data[7:0]})); // see R8
    assign forced = (cache_control_reg[`CRU_CCR_FMISS_LO] && !physical_bus_address[IW]) // see R10
                 || (cache_control_reg[`CRU_CCR_FMISS_HI] && physical_bus_address[IW]); // see R11
    assign lk_hit = s1_v && is_rd && !io_page && tmatch && !pe && !forced; // see R22 see R21

    // ------------------------------------------------------------------------
    // Cache array writes
    // ------------------------------------------------------------------------
    // The other-master check comes last and tests the old tag, so a DMA write matching it clears a line filled in the same cycle under a new tag
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < LINES; i++) begin
                cache[i] <= '0;
            end
        end else begin
            if (s1_v && s1_kind == BC_INVAL && !io_page) begin
                cache[idx].valid <= 1'b0; // see R19
            end else if (s1_v && s1_kind == BC_WRITE && !io_page) begin
                cache[idx] <= mk_line(tag, s1_wdata, cache_control_reg[`CRU_CCR_WRONG_PAR]); // see R20 see R7
            end else if (s1_v && s1_kind == BC_WRITE_BYTE && !io_page && tmatch) begin
                // A byte write only updates a line already holding this word
                cache[idx] <= mk_line(tag, physical_bus_address[0] ? {s1_wdata[7:0], ln.data[7:0]}
                                      : {ln.data[15:8], s1_wdata[7:0]},
                                      cache_control_reg[`CRU_CCR_WRONG_PAR]); // see R20 see R8
            end
            if (state == ST_FILL && fill_valid && fill_alloc) begin
                cache[fill_idx] <= mk_line(fill_tag, bus_din_i, cache_control_reg[`CRU_CCR_WRONG_PAR]); // see R2
            end
            if (dma_i.valid && dma_i.write && cache[dma_i.addr[IW:1]].tag == dma_i.addr[17:IW+1]) begin
                cache[dma_i.addr[IW:1]].valid <= 1'b0; // see R3
            end
        end
    end

    // ------------------------------------------------------------------------
    // Result stage and miss handling
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            fill_idx <= '0;
            fill_tag <= '0;
            fill_alloc <= 1'b0;
            sbus_req <= 1'b0;
            sbus_write <= 1'b0;
            data_select_mux <= 1'b0;
            mux_data <= 16'h0000;
            data_ready <= 1'b0;
            parity_err <= 1'b0;
            access_abort <= 1'b0;
        end else begin
            sbus_req <= 1'b0;
            data_ready <= 1'b0;
            parity_err <= 1'b0;
            access_abort <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (s1_v && is_rd) begin
                        parity_err <= pe;
                        if (pe && cache_control_reg[`CRU_CCR_PAR_ABORT]) begin
                            access_abort <= 1'b1; // see R9
                        end else if (lk_hit) begin
                            data_select_mux <= 1'b1; // see R2
                            mux_data <= ln.data;
                            data_ready <= 1'b1;
                        end else begin
                            sbus_req <= 1'b1;
                            sbus_write <= 1'b0;
                            data_select_mux <= 1'b0;
                            state <= ST_FILL;
                            fill_idx <= idx;
                            fill_tag <= tag;
                            fill_alloc <= !io_page; // see R21
                        end
                    end else if (s1_v && is_wr) begin
                        sbus_req <= 1'b1; // see R20
                        sbus_write <= 1'b1;
                    end
                end
                ST_FILL: begin
                    if (fill_valid) begin
                        mux_data <= bus_din_i; // see R2
                        data_select_mux <= 1'b0;
                        data_ready <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Hit indication and the tag of the last lookup, for the status read
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hit <= 1'b0;
            last_valid <= 1'b0;
            last_tag <= '0;
        end else if (s1_v && is_rd && state == ST_IDLE) begin
            hit <= lk_hit; // see R22
            last_valid <= ln.valid;
            last_tag <= ln.tag;
        end
    end

    // History shifts up on each processor read; nothing else writes it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hit_miss_history <= '0;
        end else if (s1_v && is_rd && state == ST_IDLE) begin
            hit_miss_history <= {hit_miss_history[HIST_W-2:0], lk_hit}; // see R12 see R13
        end
    end

    // ------------------------------------------------------------------------
    // Microcontrol register access
    // ------------------------------------------------------------------------
    logic uc_rd, uc_wr, uc_mm2, uc_stat;
    logic [3:0] uc_sel;
    assign uc_rd = microcontrol_interface_i.xfer && microcontrol_interface_i.code[15:10] == `CRU_UC_RD_GRP;
    assign uc_wr = microcontrol_interface_i.xfer && microcontrol_interface_i.code[15:10] == `CRU_UC_WR_GRP;
    assign uc_mm2 = microcontrol_interface_i.xfer && microcontrol_interface_i.code[15:9] == `CRU_UC_RD_MM2;
    assign uc_stat = microcontrol_interface_i.xfer && microcontrol_interface_i.code[15:9] == `CRU_UC_RD_STAT;
    assign uc_sel = microcontrol_interface_i.code[3:0];

    // Register writes; unused bits of each register stay zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cache_control_reg <= `CRU_RST_CCR;
            stack_limit_reg <= `CRU_RST_SLR;
            mm_status_zero <= 16'h0000;
            for (int i = 0; i < 16; i++) begin
                page_base_reg[i] <= 12'h000;
                page_descriptor_reg[i] <= 16'h0000;
            end
        end else if (uc_wr) begin
            unique case (uc_sel)
                `CRU_WR_CCR_BITS: cache_control_reg <= microcontrol_interface_i.dout & `CRU_CCR_MASK; // see R14
                `CRU_WR_SLR: stack_limit_reg <= microcontrol_interface_i.dout[15:8];
                `CRU_WR_CCR_SLR: begin
                    cache_control_reg <= microcontrol_interface_i.dout & `CRU_CCR_MASK;
                    stack_limit_reg <= microcontrol_interface_i.dout[15:8];
                end
                `CRU_WR_MM0: mm_status_zero <= microcontrol_interface_i.dout & `CRU_MM0_MASK;
                `CRU_WR_PDR: page_descriptor_reg[page_sel] <= microcontrol_interface_i.dout & `CRU_PDR_MASK; // see R16
                `CRU_WR_PAR: page_base_reg[page_sel] <= microcontrol_interface_i.dout[11:0];
                default: ;
            endcase
        end
    end

    // Status two holds the virtual address of the latest reference
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mm_status_two <= 16'h0000;
        end else if (ref_i.valid) begin
            mm_status_two <= ref_i.va;
        end
    end

    // Read data is driven for one cycle; the controller must keep other drivers off
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_din_o <= 16'h0000;
            bus_din_oe <= 1'b0;
        end else begin
            bus_din_oe <= uc_rd || uc_mm2 || uc_stat; // see R15
            if (uc_mm2) begin
                bus_din_o <= mm_status_two; // see R18
            end else if (uc_stat) begin
                bus_din_o <= {last_valid, last_tag, 2'h0, hit_miss_history}; // see R17
            end else if (uc_rd) begin
                unique case (uc_sel)
                    `CRU_SEL_CCR_SLR: bus_din_o <= {stack_limit_reg, cache_control_reg[7:0]};
                    `CRU_SEL_MM0: bus_din_o <= mm_status_zero;
                    `CRU_SEL_PDR: bus_din_o <= page_descriptor_reg[page_sel]; // see R16
                    `CRU_SEL_PAR: bus_din_o <= {4'h0, page_base_reg[page_sel]};
                    default: bus_din_o <= 16'h0000;
                endcase
            end else begin
                bus_din_o <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_hit_sel;
        s1_v && state == ST_IDLE && lk_hit |=> data_select_mux && data_ready && hit;
    endproperty
    a_hit_sel: assert property (p_hit_sel) else $error("hit did not select cache port"); // see R2

    property p_fill;
        state == ST_FILL && fill_valid |=> data_ready && !data_select_mux && mux_data == $past(bus_din_i);
    endproperty
    a_fill: assert property (p_fill) else $error("fill data not passed through"); // see R2

    property p_stack;
        ref_i.valid && ref_i.stack && ref_i.va < {stack_limit_reg, 8'h00} |=> stack_err;
    endproperty
    a_stack: assert property (p_stack) else $error("stack limit error missing"); // see R4

    property p_abort;
        s1_v && is_rd && state == ST_IDLE && pe && cache_control_reg[7] |=> access_abort && !sbus_req && !data_ready;
    endproperty
    a_abort: assert property (p_abort) else $error("parity abort missing"); // see R9

    property p_force_lo;
        s1_v && is_rd && state == ST_IDLE && cache_control_reg[2] && !physical_bus_address[10] |=> !hit;
    endproperty
    a_force_lo: assert property (p_force_lo) else $error("forced miss low failed"); // see R10

    property p_force_hi;
        s1_v && is_rd && state == ST_IDLE && cache_control_reg[3] && physical_bus_address[10] |=> !hit;
    endproperty
    a_force_hi: assert property (p_force_hi) else $error("forced miss high failed"); // see R11

    property p_hist;
        s1_v && is_rd && state == ST_IDLE |=> hit_miss_history[0] == hit
            && hit_miss_history[5:1] == $past(hit_miss_history[4:0]);
    endproperty
    a_hist: assert property (p_hist) else $error("history shift wrong"); // see R12

    property p_hist_ro;
        !(s1_v && is_rd && state == ST_IDLE) |=> $stable(hit_miss_history);
    endproperty
    a_hist_ro: assert property (p_hist_ro) else $error("history changed without a read"); // see R13

    property p_inval;
        s1_v && s1_kind == BC_INVAL && state == ST_IDLE |=> !sbus_req ##1 !cache[$past(idx, 2)].valid;
    endproperty
    a_inval: assert property (p_inval) else $error("invalidate misbehaved"); // see R19

    property p_write;
        s1_v && is_wr && state == ST_IDLE |=> sbus_req && sbus_write;
    endproperty
    a_write: assert property (p_write) else $error("write gave no bus cycle"); // see R20

    property p_io;
        s1_v && is_rd && state == ST_IDLE && io_page |=> !hit && sbus_req && !fill_alloc;
    endproperty
    a_io: assert property (p_io) else $error("io page was cached"); // see R21
endmodule // cru_top

//--- cru_mem_model.sv
// Backing memory model that answers the unit's system bus read cycles.
`timescale 1ns/10ps
module cru_mem_model (
    input wire logic mclk, // Microcycle clock
    input wire logic sbus_req, // Bus cycle start pulse
    input wire logic sbus_write, // The cycle writes
    input wire logic [17:0] physical_bus_address, // Bus address
    input wire logic [3:0] lat, // Reply delay in cycles, at least one
    output logic fill_valid, // Read data present
    output logic [15:0] bus_din_i // Read data
);
    logic [15:0] word;
    // Reads return a pattern made from the address; outside the reply the
    // data lines show the inverse, so a late sample never looks right
    initial begin
        fill_valid = 1'b0;
        bus_din_i = 16'hFFFF;
        forever begin
            @(posedge mclk);
            if (sbus_req && !sbus_write) begin
                word = physical_bus_address[15:0] ^ 16'h5A3C;
                repeat (lat) @(posedge mclk);
                #2;
                fill_valid = 1'b1;
                bus_din_i = word;
                @(posedge mclk);
                #2;
                fill_valid = 1'b0;
                bus_din_i = ~word;
            end
        end
    end
endmodule // cru_mem_model

//--- cache_relocation_unit_test.sv
// Self-checking bench for the cache and relocation unit.
`timescale 1ns/10ps
module cache_relocation_unit_test import cru_pkg::*;;
    logic mclk, rst_n, fill_valid, sbus_req, sbus_write, hit, data_select_mux, data_ready;
    logic parity_err, access_abort, stack_err, bus_din_oe, r_se, r_ab, r_pe, r_wr;
    logic [15:0] bus_din_i, mux_data, bus_din_o, r_d;
    logic [17:0] physical_bus_address, r_pa;
    logic [3:0] lat;
    cru_ref_s ref_i;
    cru_microcontrol_interface_s microcontrol_interface_i;
    cru_dma_s dma_i;
    int n_mismatch, n_compared, cyc, r_req, r_t;
    cru_top dut (.mclk(mclk), .rst_n(rst_n), .ref_i(ref_i), .microcontrol_interface_i(microcontrol_interface_i), .dma_i(dma_i),
        .fill_valid(fill_valid), .bus_din_i(bus_din_i), .physical_bus_address(physical_bus_address),
        .sbus_req(sbus_req), .sbus_write(sbus_write), .hit(hit), .data_select_mux(data_select_mux),
        .mux_data(mux_data), .data_ready(data_ready), .parity_err(parity_err),
        .access_abort(access_abort), .stack_err(stack_err), .bus_din_o(bus_din_o), .bus_din_oe(bus_din_oe));
    cru_mem_model mem (.mclk(mclk), .sbus_req(sbus_req), .sbus_write(sbus_write),
        .physical_bus_address(physical_bus_address), .lat(lat), .fill_valid(fill_valid), .bus_din_i(bus_din_i));
    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Microcontrol transfer; read data stands one cycle from the taking edge,
    // so it is taken there before the transfer is dropped
    task automatic uc(input logic [15:0] code, input logic [15:0] dout);
        @(posedge mclk);
        #2;
        microcontrol_interface_i = '{1'b1, code, dout};
        @(posedge mclk);
        #1;
        r_d = bus_din_oe ? bus_din_o : 16'hxxxx;
        #1;
        microcontrol_interface_i.xfer = 1'b0;
    endtask
    // One reference; waits for data, or gives up after 8 quiet cycles
    task automatic rf(input cru_bus_e k, input logic [15:0] va, input logic stk);
        logic pend;
        pend = 1'b0;
        {r_req, r_t, r_se, r_ab, r_pe, r_wr} = '0;
        @(posedge mclk);
        #2;
        ref_i = '{1'b1, k, 1'b0, stk, va, 16'h1234};
        @(posedge mclk);
        #2;
        ref_i.valid = 1'b0;
        // The stack error pulse stands only in the cycle after the taking edge
        r_se = stack_err;
        for (int i = 1; i < 40 && r_t == 0; i++) begin
            @(posedge mclk);
            #1;
            if (i == 1) r_pa = physical_bus_address;
            r_se |= stack_err;
            r_ab |= access_abort;
            r_pe |= parity_err;
            if (sbus_req) begin
                r_req++;
                r_wr = sbus_write;
                pend |= !sbus_write;
            end
            if (data_ready) begin
                r_t = i;
                r_d = mux_data;
            end else if (i >= 8 && !pend) r_t = -1;
        end
    endtask
    // Read with relocation off: a hit answers one edge after the taking edge
    task automatic rd(input logic [15:0] va, input int miss);
        rf(BC_READ, va, 1'b0);
        chk(18'(r_req), 18'(miss));
        chk(18'(r_d), 18'(va ^ 16'h5A3C));
        chk(18'(r_t == 1), 18'(miss == 0));
        chk(18'(data_select_mux), 18'(miss == 0));
    endtask
    task automatic close_out;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Clock and hang guard; the sequence needs well under a thousand cycles
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            close_out();
        end
    end
    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        {rst_n, ref_i, microcontrol_interface_i, dma_i} = '0;
        lat = 4'd1;
        repeat (6) @(posedge mclk);
        #2;
        rst_n = 1'b1;
        uc(16'h8A00, 16'h0000);
        chk(18'(r_d), 18'h0);
        uc(16'h8400, 16'h0000);
        chk(18'(r_d), 18'h0);
        rd(16'h0040, 1);
        chk(r_pa, 18'h00040);
        rd(16'h0040, 0);
        chk(18'(hit), 18'h1);
        uc(16'h8A00, 16'h0000);
        chk(18'(r_d[5:0]), 18'h01);
        uc(16'h8004, 16'hFFFF);
        uc(16'h8400, 16'h0000);
        chk(18'(r_d), 18'h000CC);
        uc(16'h8004, 16'h0000);
        rd(16'h0440, 1);
        uc(16'h8004, 16'h0008);
        rd(16'h0440, 1);
        rd(16'h0040, 0);
        uc(16'h8004, 16'h0004);
        rd(16'h0040, 1);
        rd(16'h0440, 0);
        lat = 4'd6;
        uc(16'h8004, 16'h0040);
        rf(BC_WRITE, 16'h0080, 1'b0);
        chk(18'({r_req, r_wr}), 18'h3);
        rf(BC_WRITE_BYTE, 16'h0081, 1'b0);
        chk(18'({r_req, r_wr}), 18'h3);
        rf(BC_WRITE, 16'h00A0, 1'b0);
        uc(16'h8004, 16'h0000);
        rd(16'h0080, 1);
        chk(18'(r_pe), 18'h1);
        rd(16'h0080, 0);
        uc(16'h8004, 16'h0080);
        rf(BC_READ, 16'h00A0, 1'b0);
        chk(18'({r_ab, r_t == -1}), 18'h3);
        uc(16'h8004, 16'h0000);
        rf(BC_INVAL, 16'h0080, 1'b0);
        chk(18'(r_req), 18'h0);
        rd(16'h0080, 1);
        @(posedge mclk);
        #2;
        dma_i = '{1'b1, 1'b1, 18'h00080};
        @(posedge mclk);
        #2;
        dma_i.valid = 1'b0;
        rd(16'h0080, 1);
        rd(16'hE000, 1);
        chk(r_pa, 18'h3E000);
        rd(16'hE000, 1);
        uc(16'h8008, 16'h1000);
        rf(BC_READ, 16'h0FFE, 1'b1);
        chk(18'(r_se), 18'h1);
        rf(BC_READ, 16'h1000, 1'b1);
        chk(18'(r_se), 18'h0);
        uc(16'h8800, 16'h0000);
        chk(18'(r_d), 18'h01000);
        ref_i.user = 1'b1;
        ref_i.va = 16'h4000;
        uc(16'h800F, 16'h0123);
        uc(16'h8403, 16'h0000);
        chk(18'(r_d), 18'h00123);
        ref_i.user = 1'b0;
        uc(16'h8403, 16'h0000);
        chk(18'(r_d), 18'h0);
        // Outcomes M H H M H H H leave the last six as 110111
        for (int i = 0; i < 7; i++) rd(i < 3 ? 16'h0200 : 16'h0300, int'(i == 0 || i == 3));
        uc(16'h8A00, 16'h0000);
        chk(18'(r_d[5:0]), 18'h37);
        uc(16'h8001, 16'hFFFF);
        uc(16'h8A00, 16'h0000);
        chk(18'(r_d[5:0]), 18'h37);
        close_out();
    end
endmodule // cache_relocation_unit_test
